/* File: verilog/sdf_top.sv */
// Sigma-delta filter unit: serial/parallel input, sinc filter, integrator, output stage and detectors.
// What this block does
// RULE1 - SPI or Manchester input, selectable edge
// RULE2 - Accepts microphone pulse-density one-bit streams
// RULE3 - Two channels share pins, opposite edges
// RULE4 - Clock from input pin or internal generator
// RULE5 - Manchester recovers clock from data alone
// RULE6 - Flag missing serial clock for interrupt
// RULE7 - Skipper discards programmed number of samples
// RULE8 - Bus-written 16-bit parallel input feeds filter
// RULE9 - Sinc orders one to five, fast variant
// RULE10 - Oversampling ratio programmable per order range
// RULE11 - Filter arithmetic is 32 bits wide
// RULE12 - Integrator sums 1 to 256 filter outputs
// RULE13 - Output right shift fits 24-bit result
// RULE14 - Signed 24-bit offset added to results
// RULE15 - All arithmetic in two's complement
// RULE16 - Watchdog limits raise flag or break
// RULE17 - Watchdog watches output or raw filtered stream
// RULE18 - Short detector counts identical bits, 1-256
// RULE19 - Short event fires when run reaches threshold
// RULE20 - Short event flags and/or drives break
// RULE21 - Track running minimum and maximum of results
// RULE22 - Reading extremes register reloads and restarts
// RULE23 - Filter emits one output per ratio inputs
// RULE24 - First result after order times ratio inputs
// RULE25 - Output shift is arithmetic, keeps sign
`timescale 1ns/1ps
module sdf_top import sdf_pkg::*; #(
  parameter int CKABS_LIMIT = SDF_CKABS_CYC
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Register bus
  input  wire sdf_axi_req_t axi_req,
  output sdf_axi_rsp_t      axi_rsp,
  // Modulator link
  input  wire logic         serial_data_in_pin,
  input  wire logic         serial_clock_in_pin,
  output logic              modulator_clock_out_pin,
  // Events and breaks
  output logic              result_valid,
  output logic              watchdog_break,
  output logic              short_break
);
  typedef struct packed {
    logic [31:0] ctrl, ratio, mon, wdhi, wdlo;
    logic [23:0] ofs, data, maxv, minv;
    logic [3:0]  st;
    logic [7:0]  skip;
    logic        ck_s1, ck_s2, ck_d, dt_s1, dt_s2, dt_d;
    logic [7:0]  div;
    logic        ckout;
    logic [11:0] mtim;
    logic        mbit;
    logic [15:0] ckabs;
    sdf_state_t  state;
    logic [2:0]  fill;
    sdf_cic_t    cic, wcic;
    logic [31:0] acc;
    logic [7:0]  icnt;
    logic        lastbit;
    logic [8:0]  run;
    logic        bvalid, rvalid;
    logic [31:0] rdata;
    logic [1:0]  bresp, rresp;
    logic        rvld_o;
  } sdf_regs_t;

  sdf_regs_t r_reg, r_next;
  logic signed [31:0] res_full, filt_y, wd_y, x_in, ival;
  logic               dec, wdec, stb, stb_raw, res_stb, scd_evt, wd_evt, wr_go, rd_go, int_out;
  logic               sbit;
  logic [2:0]         ord, word;
  sdf_src_t           src;

  // ---------------------------------------------------------------
  // Shared arithmetic
  // ---------------------------------------------------------------
  // Integrators run at the input rate, combs at the decimated rate; wrap-around is harmless in a CIC.
  function automatic void cic_step(input sdf_cic_t s, input logic signed [31:0] x, input logic [2:0] o,
                                   input logic [9:0] osr_m1, output sdf_cic_t n, output logic d,
                                   output logic signed [31:0] y);
    logic signed [31:0] v;
    n = s;
    d = 1'b0;
    y = '0;
    v = '0;
    n.integ[0] = s.integ[0] + x; // RULE11
    for (int k = 1; k < 5; k++) begin
      n.integ[k] = s.integ[k] + n.integ[k-1];
    end
    if (s.cnt >= osr_m1) begin
      n.cnt = '0;
      d = 1'b1; // RULE23
      v = n.integ[o - 3'd1]; // RULE9
      for (int k = 0; k < 5; k++) begin
        if (k < int'(o)) begin
          n.dly[k] = v;
          v = v - s.dly[k];
        end
      end
      y = v;
    end else begin
      n.cnt = s.cnt + 10'd1; // RULE10
    end
  endfunction

  function automatic logic [2:0] map_order(input logic [2:0] f);
    // Code 0 selects the fast variant, built here as a second-order stage.
    if (f == 3'd0) begin
      map_order = 3'd2;
    end else if (f > 3'd5) begin
      map_order = 3'd5;
    end else begin
      map_order = f;
    end
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic        rise, fall, s0, s1, trans, en, wsel, rsel, fdone;
    logic [11:0] half;
    logic [7:0]  waddr, raddr;
    logic [3:0]  set, clr;
    sdf_cic_t    c_n, w_n;
    logic signed [31:0] wdv;
    r_next = r_reg;
    rise = 1'b0;
    fall = 1'b0;
    s0 = 1'b0;
    s1 = 1'b0;
    trans = 1'b0;
    wsel = 1'b0;
    rsel = 1'b0;
    fdone = 1'b0;
    wdv = '0;
    set = '0;
    clr = '0;
    c_n = r_reg.cic;
    w_n = r_reg.wcic;
    en = r_reg.ctrl[SDF_EN_BIT];
    src = sdf_src_t'(r_reg.ctrl[SDF_SRC_LSB +: 2]);
    ord = map_order(r_reg.ctrl[SDF_ORD_LSB +: 3]);
    word = (r_reg.mon[SDF_WFORD_LSB +: 2] == 2'd0) ? 3'd1 : {1'b0, r_reg.mon[SDF_WFORD_LSB +: 2]};
    half = {4'h0, r_reg.ctrl[SDF_DIV_LSB +: 8]} + 12'd1;
    waddr = axi_req.awaddr;
    raddr = axi_req.araddr;
    wr_go = axi_req.awvalid && axi_req.wvalid && !r_reg.bvalid;
    rd_go = axi_req.arvalid && !r_reg.rvalid;
    stb = 1'b0;
    stb_raw = 1'b0;
    sbit = 1'b0;
    x_in = '0;
    dec = 1'b0;
    wdec = 1'b0;
    filt_y = '0;
    wd_y = '0;
    res_stb = 1'b0;
    res_full = '0;
    ival = '0;
    int_out = 1'b0;
    scd_evt = 1'b0;
    wd_evt = 1'b0;
    // Pins pass two flops; edges and transitions compare the second with a third, delayed copy of it.
    r_next.ck_s1 = serial_clock_in_pin;
    r_next.ck_s2 = r_reg.ck_s1;
    r_next.ck_d = r_reg.ck_s2;
    r_next.dt_s1 = serial_data_in_pin;
    r_next.dt_s2 = r_reg.dt_s1;
    r_next.dt_d = r_reg.dt_s2;
    // Clock source and sample strobes.
    if (src == SRC_SPI_INT && en) begin
      if (r_reg.div >= r_reg.ctrl[SDF_DIV_LSB +: 8]) begin
        r_next.div = '0;
        r_next.ckout = !r_reg.ckout; // RULE4
        rise = !r_reg.ckout;
        fall = r_reg.ckout;
      end else begin
        r_next.div = r_reg.div + 8'd1;
      end
    end else begin
      r_next.div = '0;
      r_next.ckout = 1'b0;
      rise = r_reg.ck_s2 && !r_reg.ck_d; // RULE4
      fall = !r_reg.ck_s2 && r_reg.ck_d;
    end
    s0 = r_reg.ctrl[SDF_EDGE_BIT] ? fall : rise; // RULE1
    s1 = r_reg.ctrl[SDF_EDGE_BIT] ? rise : fall; // RULE3
    // Manchester: a transition later than one and a half half-bits after the last accepted one is a mid-bit.
    trans = r_reg.dt_s2 ^ r_reg.dt_d;
    if (r_reg.mtim != 12'hfff) begin
      r_next.mtim = r_reg.mtim + 12'd1;
    end
    if (src == SRC_MANCH) begin
      if (trans && ({r_reg.mtim, 1'b0} > {1'b0, half} + {half, 1'b0})) begin
        r_next.mtim = '0;
        stb_raw = 1'b1; // RULE5
        sbit = r_reg.dt_s2;
      end
    end else if (src != SRC_PAR) begin
      stb_raw = r_reg.ctrl[SDF_CHSEL_BIT] ? s1 : s0; // RULE2
      sbit = r_reg.dt_s2;
    end
    // Clock presence, meaningful only when the modulator supplies the clock.
    if (rise || fall || src != SRC_SPI_EXT || !en) begin
      r_next.ckabs = '0;
    end else if (r_reg.ckabs != 16'hffff) begin
      r_next.ckabs = r_reg.ckabs + 16'd1;
    end
    if (en && src == SRC_SPI_EXT && r_reg.ckabs == 16'(CKABS_LIMIT)) begin
      set[SDF_ST_CKABS] = 1'b1; // RULE6
    end
    // Pulse skipper drops samples before every consumer.
    stb = stb_raw && en;
    if (stb && r_reg.skip != 8'd0) begin
      r_next.skip = r_reg.skip - 8'd1; // RULE7
      stb = 1'b0;
    end
    x_in = sbit ? 32'sd1 : -32'sd1; // RULE15
    if (src == SRC_PAR) begin
      stb = en && wr_go && waddr == SDF_PAR_OFS; // RULE8
      x_in = {{16{axi_req.wdata[15]}}, axi_req.wdata[15:0]};
    end
    // Short-circuit detector on the one-bit stream.
    if (stb && src != SRC_PAR) begin
      r_next.lastbit = sbit;
      if (sbit == r_reg.lastbit && r_reg.run != 9'h1ff) begin
        r_next.run = r_reg.run + 9'd1; // RULE18
      end else if (sbit != r_reg.lastbit) begin
        r_next.run = 9'd1;
      end
      if (r_next.run == {1'b0, r_reg.mon[SDF_SHORT_DETECT_THRESHOLD_LSB +: 8]} + 9'd1 && r_next.run != r_reg.run) begin
        scd_evt = 1'b1; // RULE19
      end
    end
    if (scd_evt) begin
      set[SDF_ST_SCD] = 1'b1; // RULE20
    end
    // Main filter with fill phase.
    if (stb) begin
      cic_step(r_reg.cic, x_in, ord, r_reg.ratio[9:0], c_n, dec, filt_y);
      r_next.cic = c_n;
    end
    case (r_reg.state)
      ST_IDLE: begin
        r_next.cic = '0;
        r_next.fill = '0;
        r_next.acc = '0;
        r_next.icnt = '0;
        if (en) begin
          r_next.state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (dec) begin
          r_next.fill = r_reg.fill + 3'd1;
          if (r_reg.fill + 3'd1 >= ord) begin
            r_next.state = ST_RUN; // RULE24
            fdone = 1'b1;
          end
        end
      end
      ST_RUN: begin
        fdone = dec;
      end
      default: r_next.state = ST_IDLE;
    endcase
    // The decimation that fills the last comb stage already carries a valid result.
    if (fdone) begin
      ival = r_reg.acc + filt_y; // RULE12
      if (!r_reg.ctrl[SDF_INTEN_BIT] || r_reg.icnt >= r_reg.ratio[SDF_INTEGRATOR_OVERSAMPLING_RATIO_LSB +: 8]) begin
        int_out = 1'b1;
        r_next.acc = '0;
        r_next.icnt = '0;
      end else begin
        r_next.acc = ival;
        r_next.icnt = r_reg.icnt + 8'd1;
      end
    end
    if (!en) begin
      r_next.state = ST_IDLE;
    end
    if (int_out) begin
      // An unsigned offset operand would turn the arithmetic shift into a logical one.
      res_full = (ival >>> r_reg.ctrl[SDF_SHIFT_LSB +: 5]) + $signed({{8{r_reg.ofs[23]}}, r_reg.ofs}); // RULE13 RULE14 RULE25
      res_stb = 1'b1;
      r_next.data = res_full[23:0];
      set[SDF_ST_VALID] = 1'b1;
    end
    // Raw-stream monitor filter.
    if (stb && src != SRC_PAR) begin
      cic_step(r_reg.wcic, x_in, word, {5'h0, r_reg.mon[4:0]}, w_n, wdec, wd_y); // RULE17
      r_next.wcic = w_n;
    end
    if (r_reg.ctrl[SDF_WDRAW_BIT] ? wdec : res_stb) begin
      wdv = r_reg.ctrl[SDF_WDRAW_BIT] ? wd_y : {{8{res_full[23]}}, res_full[23:0]};
      wd_evt = $signed(wdv) > $signed(r_reg.wdhi) || $signed(wdv) < $signed(r_reg.wdlo); // RULE16
    end
    if (wd_evt) begin
      set[SDF_ST_WD] = 1'b1;
    end
    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    if (r_reg.bvalid && axi_req.bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.rvalid && axi_req.rready) begin
      r_next.rvalid = 1'b0;
    end
    if (wr_go) begin
      r_next.bvalid = 1'b1;
      r_next.bresp = SDF_RESP_OK;
      wsel = 1'b1;
      case (waddr)
        SDF_CTRL_OFS:  r_next.ctrl = axi_req.wdata;
        SDF_RATIO_OFS: r_next.ratio = axi_req.wdata;
        SDF_PAR_OFS:   r_next.bresp = SDF_RESP_OK;
        SDF_OFFS_OFS:  r_next.ofs = axi_req.wdata[23:0];
        SDF_WDHI_OFS:  r_next.wdhi = axi_req.wdata;
        SDF_WDLO_OFS:  r_next.wdlo = axi_req.wdata;
        SDF_MON_OFS:   r_next.mon = axi_req.wdata;
        SDF_SKIP_OFS:  r_next.skip = axi_req.wdata[7:0];
        SDF_STAT_OFS:  clr = axi_req.wdata[3:0];
        default:       r_next.bresp = SDF_RESP_DEC;
      endcase
    end
    // Reading the result clears its valid flag; a new result in the same cycle still sets it.
    if (rd_go) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = SDF_RESP_OK;
      rsel = 1'b1;
      case (raddr)
        SDF_CTRL_OFS:  r_next.rdata = r_reg.ctrl;
        SDF_RATIO_OFS: r_next.rdata = r_reg.ratio;
        SDF_OFFS_OFS:  r_next.rdata = {8'h00, r_reg.ofs};
        SDF_WDHI_OFS:  r_next.rdata = r_reg.wdhi;
        SDF_WDLO_OFS:  r_next.rdata = r_reg.wdlo;
        SDF_MON_OFS:   r_next.rdata = r_reg.mon;
        SDF_SKIP_OFS:  r_next.rdata = {24'h0, r_reg.skip};
        SDF_STAT_OFS:  r_next.rdata = {28'h0, r_reg.st};
        SDF_DATA_OFS: begin
          r_next.rdata = {{8{r_reg.data[23]}}, r_reg.data};
          clr[SDF_ST_VALID] = 1'b1;
        end
        SDF_MAX_OFS: begin
          r_next.rdata = {{8{r_reg.maxv[23]}}, r_reg.maxv};
          r_next.maxv = SDF_MAX_RST; // RULE22
        end
        SDF_MIN_OFS: begin
          r_next.rdata = {{8{r_reg.minv[23]}}, r_reg.minv};
          r_next.minv = SDF_MIN_RST; // RULE22
        end
        default: begin
          r_next.rdata = '0;
          r_next.rresp = SDF_RESP_DEC;
        end
      endcase
    end
    if (res_stb) begin
      if ($signed(res_full[23:0]) > $signed(r_next.maxv)) begin
        r_next.maxv = res_full[23:0]; // RULE21
      end
      if ($signed(res_full[23:0]) < $signed(r_next.minv)) begin
        r_next.minv = res_full[23:0]; // RULE21
      end
    end
    r_next.st = (r_reg.st & ~clr) | set;
    r_next.rvld_o = res_stb;
  end

  // ---------------------------------------------------------------
  // State register and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.ctrl <= SDF_CTRL_RST;
      r_reg.maxv <= SDF_MAX_RST;
      r_reg.minv <= SDF_MIN_RST;
      r_reg.state <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign modulator_clock_out_pin = r_reg.ckout;
  assign result_valid = r_reg.rvld_o;
  assign watchdog_break = r_reg.st[SDF_ST_WD] && r_reg.ctrl[SDF_WDBRK_BIT]; // RULE16
  assign short_break = r_reg.st[SDF_ST_SCD] && r_reg.ctrl[SDF_SCBRK_BIT]; // RULE20
  assign axi_rsp = '{awready: wr_go, wready: wr_go, bvalid: r_reg.bvalid, bresp: r_reg.bresp,
                     arready: rd_go, rvalid: r_reg.rvalid, rdata: r_reg.rdata, rresp: r_reg.rresp};

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bresp_follow_a: assert property (wr_go |=> r_reg.bvalid) else $error("write answer missing");
  skip_count_a: assert property (stb_raw && en_chk() && r_reg.skip != 8'd0 |-> !stb ##1 r_reg.skip == $past(r_reg.skip) - 8'd1) else $error("skipper slip"); // RULE7
  fill_quiet_a: assert property (r_reg.state != ST_RUN && !(dec && r_reg.fill + 3'd1 >= ord) |-> !res_stb)
    else $error("result during fill"); // RULE24
  short_fire_a: assert property (scd_evt |-> r_next.run == {1'b0, r_reg.mon[SDF_SHORT_DETECT_THRESHOLD_LSB +: 8]} + 9'd1 ##1 r_reg.st[SDF_ST_SCD]) else $error("short event mistimed"); // RULE19
  shift_sign_a: assert property (res_stb && r_reg.ofs == 24'h0 && r_reg.ctrl[SDF_SHIFT_LSB +: 5] == 5'd12
    |-> res_full[23:0] == {{4{ival[31]}}, ival[31:12]}) else $error("shift wrong"); // RULE25
  max_reload_a: assert property (rd_go && axi_req.araddr == SDF_MAX_OFS && !res_stb |=> r_reg.maxv == SDF_MAX_RST) else $error("max not reloaded"); // RULE22
  wd_flag_a: assert property (wd_evt |=> r_reg.st[SDF_ST_WD] [*2]) else $error("watchdog flag lost"); // RULE16
  ckabs_flag_a: assert property (r_reg.ctrl[SDF_EN_BIT] && src == SRC_SPI_EXT && r_reg.ckabs == 16'(CKABS_LIMIT) |=> r_reg.st[SDF_ST_CKABS]) else $error("clock loss missed"); // RULE6
  ckout_stop_a: assert property (src != SRC_SPI_INT |=> !modulator_clock_out_pin) else $error("clock out runs"); // RULE4
  run_cov: cover property (r_reg.state == ST_FILL ##[1:1000] r_reg.state == ST_RUN ##[1:1000] res_stb);
  short_cov: cover property (scd_evt);
  wd_cov: cover property (wd_evt && r_reg.ctrl[SDF_WDRAW_BIT]);

  function automatic logic en_chk();
    en_chk = r_reg.ctrl[SDF_EN_BIT];
  endfunction
endmodule

/* File: common/sdf_pkg.sv */
// Package with the register map, field layout, timing constants and types of the sigma-delta filter unit.
package sdf_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SDF_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SDF_RATIO_OFS  = 8'h04;
  localparam logic [7:0] SDF_PAR_OFS    = 8'h08;
  localparam logic [7:0] SDF_OFFS_OFS   = 8'h0c;
  localparam logic [7:0] SDF_WDHI_OFS   = 8'h10;
  localparam logic [7:0] SDF_WDLO_OFS   = 8'h14;
  localparam logic [7:0] SDF_MON_OFS    = 8'h18;
  localparam logic [7:0] SDF_SKIP_OFS   = 8'h1c;
  localparam logic [7:0] SDF_STAT_OFS   = 8'h20;
  localparam logic [7:0] SDF_DATA_OFS   = 8'h24;
  localparam logic [7:0] SDF_MAX_OFS    = 8'h28;
  localparam logic [7:0] SDF_MIN_OFS    = 8'h2c;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int SDF_EN_BIT     = 0;
  localparam int SDF_SRC_LSB    = 1;
  localparam int SDF_EDGE_BIT   = 3;
  localparam int SDF_CHSEL_BIT  = 4;
  localparam int SDF_INTEN_BIT  = 5;
  localparam int SDF_WDRAW_BIT  = 6;
  localparam int SDF_DIV_LSB    = 8;
  localparam int SDF_ORD_LSB    = 16;
  localparam int SDF_SHIFT_LSB  = 24;
  localparam int SDF_WDBRK_BIT  = 29;
  localparam int SDF_SCBRK_BIT  = 30;
  localparam int SDF_INTEGRATOR_OVERSAMPLING_RATIO_LSB   = 16;
  localparam int SDF_WFORD_LSB  = 8;
  localparam int SDF_SHORT_DETECT_THRESHOLD_LSB   = 16;
  localparam int SDF_ST_VALID   = 0;
  localparam int SDF_ST_CKABS   = 1;
  localparam int SDF_ST_WD      = 2;
  localparam int SDF_ST_SCD     = 3;
  localparam logic [31:0] SDF_CTRL_RST = 32'h0001_0300;
  localparam logic [23:0] SDF_MAX_RST  = 24'h80_0000;
  localparam logic [23:0] SDF_MIN_RST  = 24'h7f_ffff;
  localparam logic [1:0]  SDF_RESP_OK  = 2'h0;
  localparam logic [1:0]  SDF_RESP_DEC = 2'h3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SDF_CLK_MHZ      = 100;
  localparam int SDF_CKABS_NS     = 2000;
  localparam int SDF_CKABS_CYC    = SDF_CKABS_NS * SDF_CLK_MHZ / 1000;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRC_SPI_EXT = 2'h0, SRC_SPI_INT = 2'h1, SRC_MANCH = 2'h2, SRC_PAR = 2'h3} sdf_src_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_FILL = 2'h1, ST_RUN = 2'h3} sdf_state_t;
  typedef struct packed {
    logic [4:0][31:0] integ;
    logic [4:0][31:0] dly;
    logic [9:0]       cnt;
  } sdf_cic_t;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } sdf_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sdf_axi_rsp_t;
endpackage

/* File: verification/sdf_mod_model.sv */
// Behavioural sigma-delta modulator that makes its own link clock and one-bit stream.
`timescale 1ns/1ps
module sdf_mod_model (
  // Bench control
  input  wire logic       run,
  input  wire logic [1:0] mode,
  // Link pins
  output logic            clk_pin,
  output logic            dat_pin
);
  logic alt;
  // -------------------------------------------------------------
  // Link clock and data
  // -------------------------------------------------------------
  // The 3 ns offset keeps link edges off the system clock edges.
  // The clock parks low between frames and the idle data line toggles, so a stale bit is never seen.
  initial begin
    clk_pin = 1'b0;
    dat_pin = 1'b0;
    alt     = 1'b0;
    #3;
    forever begin
      #40;
      if (run || clk_pin) begin
        clk_pin = ~clk_pin;
      end
      if (!clk_pin) begin
        alt     = ~alt;
        dat_pin = run ? ((mode == 2'h2) ? alt : ~mode[0]) : ~dat_pin;
      end
    end
  end
endmodule

/* File: verification/sdf_top_tb_top.sv */
// Self-checking bench for the sigma-delta filter unit over its register bus and modulator link.
`timescale 1ns/1ps
module sdf_top_tb_top import sdf_pkg::*; ;
  logic         aclk;
  logic         aresetn;
  sdf_axi_req_t req;
  sdf_axi_rsp_t rsp;
  logic         ck_pin;
  logic         dat_pin;
  logic         mclk_out;
  logic         res_valid;
  logic         wd_brk;
  logic         sc_brk;
  logic         run;
  logic         lastc;
  logic [1:0]   mode;
  logic [1:0]   rr;
  logic [31:0]  rd;
  int           err_total;
  int           samples_checked;
  int           nres;
  int           n;
  int           o;

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (res_valid === 1'b1) begin
      nres++;
    end
  end

  sdf_top #(.CKABS_LIMIT(40)) dut (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .axi_req                 (req),
    .axi_rsp                 (rsp),
    .serial_data_in_pin      (dat_pin),
    .serial_clock_in_pin     (ck_pin),
    .modulator_clock_out_pin (mclk_out),
    .result_valid            (res_valid),
    .watchdog_break          (wd_brk),
    .short_break             (sc_brk)
  );
  sdf_mod_model model (.run(run), .mode(mode), .clk_pin(ck_pin), .dat_pin(dat_pin));

  // -------------------------------------------------------------
  // Checking and bus tasks
  // -------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits for awready, bvalid, arready or rvalid; a hung bus ends the run.
  task automatic wfor(input int w);
    int k;
    logic [3:0] f;
    k = 0;
    do begin
      @(posedge aclk);
      f = {rsp.rvalid, rsp.arready, rsp.bvalid, rsp.awready};
      k++;
    end while (f[w] !== 1'b1 && k < 200);
    if (k >= 200) begin
      chk("bus answer", 32'h1, 32'h0);
      end_of_test;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    wfor(0);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    wfor(1);
    req.bready  <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    wfor(2);
    req.arvalid <= 1'b0;
    wfor(3);
    req.rready  <= 1'b0;
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(nm, exp, rd);
  endtask
  // Feeds parallel words and counts results; reading the extremes first restarts their tracking.
  task automatic par_case(input logic [31:0] ctl, input logic [31:0] rat, input logic [23:0] off,
                          input logic [15:0] s0, input logic [15:0] s1, input int nf, input int more,
                          input logic [31:0] exp);
    int base;
    int e;
    axw(SDF_CTRL_OFS, ctl & 32'hffff_fffe);
    axw(SDF_RATIO_OFS, rat);
    axw(SDF_OFFS_OFS, {8'h00, off});
    axw(SDF_STAT_OFS, 32'h0000_000f);
    axr(SDF_MAX_OFS);
    axr(SDF_MIN_OFS);
    base = nres;
    axw(SDF_CTRL_OFS, ctl);
    for (int i = 1; i <= nf + more; i++) begin
      axw(SDF_PAR_OFS, {16'h0000, (i == 1) ? s0 : s1});
      e = (i < nf) ? 0 : ((more > 0 && i == nf + more) ? 2 : 1);
      for (int k = 0; k < 30 && nres - base < e; k++) begin
        @(posedge aclk);
      end
      chk("result count", 32'(e), 32'(nres - base));
    end
    rchk("data", SDF_DATA_OFS, exp);
    chk("watchdog break", ($signed(exp) > 32'sd10 || $signed(exp) < -32'sd10) ? 32'h1 : 32'h0, {31'h0, wd_brk});
    rchk("max", SDF_MAX_OFS, exp);
    rchk("min", SDF_MIN_OFS, exp);
    rchk("max reload", SDF_MAX_OFS, 32'hff80_0000);
  endtask

  // -------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    run = 1'b0;
    mode = 2'h2;
    err_total = 0;
    samples_checked = 0;
    nres = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl reset", SDF_CTRL_OFS, SDF_CTRL_RST);
    rchk("min reset", SDF_MIN_OFS, 32'h007f_ffff);
    axr(8'h30);
    chk("unmapped resp", {30'h0, SDF_RESP_DEC}, {30'h0, rr});
    chk("unmapped data", 32'h0, rd);
    $display("test registers done");
    axw(SDF_WDHI_OFS, 32'h0000_000a);
    axw(SDF_WDLO_OFS, 32'hffff_fff6);
    par_case(32'h2101_0307, 32'h1, 24'h3, 16'hfffb, 16'hfffd, 2, 0, 32'hffff_ffff);
    par_case(32'h2001_0327, 32'h0001_0000, 24'h0, 16'h0007, 16'hfffe, 2, 0, 32'h5);
    par_case(32'h2c03_0307, 32'h1, 24'h0, 16'h8000, 16'h8000, 6, 0, 32'hffff_ffc0);
    for (o = 0; o < 6; o++) begin
      n = (o == 0) ? 2 : o;
      par_case(32'h2000_0307 | (32'(o) << 16), 32'h1, 24'h0, 16'h1, 16'h1, 2 * n, 2, 32'h1 << n);
    end
    $display("test parallel done");
    axw(SDF_CTRL_OFS, 32'h0000_0303);
    repeat (8) @(posedge aclk);
    n = 0;
    lastc = mclk_out;
    for (o = 0; o < 80; o++) begin
      @(posedge aclk);
      if (mclk_out !== lastc) begin
        n++;
      end
      lastc = mclk_out;
    end
    chk("clock out toggles", 32'd20, 32'(n));
    $display("test clock out done");
    axw(SDF_CTRL_OFS, 32'h4000_0300);
    axw(SDF_RATIO_OFS, 32'h3);
    axw(SDF_OFFS_OFS, 32'h0);
    axw(SDF_MON_OFS, 32'h0007_0000);
    run <= 1'b1;
    axw(SDF_CTRL_OFS, 32'h4001_0301);
    repeat (160) @(posedge aclk);
    axw(SDF_STAT_OFS, 32'h0000_000f);
    axr(SDF_STAT_OFS);
    chk("no short or clock loss", 32'h0, rd & 32'he);
    axw(SDF_SKIP_OFS, 32'h0000_0004);
    axw(SDF_CTRL_OFS, 32'h4001_0305);
    axw(SDF_STAT_OFS, 32'h0000_000f);
    repeat (160) @(posedge aclk);
    axr(SDF_STAT_OFS);
    chk("manchester results", 32'h1, rd & 32'h9);
    rchk("manchester data", SDF_DATA_OFS, 32'h0);
    rchk("skip drained", SDF_SKIP_OFS, 32'h0);
    axw(SDF_CTRL_OFS, 32'h4001_0301);
    mode <= 2'h0;
    for (n = 0; n < 200 && sc_brk !== 1'b1; n++) begin
      @(posedge aclk);
    end
    chk("short delay in range", 32'h1, {31'h0, n >= 48 && n < 120});
    axr(SDF_STAT_OFS);
    chk("short flag", 32'h8, rd & 32'h8);
    repeat (100) @(posedge aclk);
    rchk("serial ones result", SDF_DATA_OFS, 32'h4);
    axw(SDF_WDHI_OFS, 32'h0);
    axw(SDF_CTRL_OFS, 32'h4001_0341);
    axw(SDF_STAT_OFS, 32'h0000_000f);
    repeat (40) @(posedge aclk);
    axr(SDF_STAT_OFS);
    chk("raw watchdog flag", 32'h4, rd & 32'h4);
    run <= 1'b0;
    repeat (80) @(posedge aclk);
    axr(SDF_STAT_OFS);
    chk("clock absent", 32'h2, rd & 32'h2);
    $display("test serial done");
    end_of_test;
  end
endmodule
